// File: rtl/rsd_consts.svh
`ifndef RSD_CONSTS_SVH
`define RSD_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, low eight address bits)
// ----------------------------------------------------------------
`define RSD_OFF_CTRL      8'h00
`define RSD_OFF_IN_PRE    8'h04
`define RSD_OFF_FB_PRE    8'h08
`define RSD_OFF_OUT_BASE  8'h10
`define RSD_OFF_STATUS    8'h24
`define RSD_OFF_STRIDE    8'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSD_CTRL_IN_BYP   0
`define RSD_CTRL_FB_BYP   1
`define RSD_CTRL_ROUTE    2
`define RSD_OUT_RATIO_LSB 0
`define RSD_OUT_RATIO_MSB 6
`define RSD_OUT_SKEW_LSB  8
`define RSD_OUT_SKEW_MSB  11
`define RSD_PRE_MSB       5

// ----------------------------------------------------------------
// Limits, reset values and bus codes
// ----------------------------------------------------------------
`define RSD_NUM_OUT       5
`define RSD_PRE_MIN       6'h01
`define RSD_PRE_MAX       6'h28
`define RSD_DIV_MIN       7'h02
`define RSD_DIV_MAX       7'h50
`define RSD_PRE_RESET     6'h01
`define RSD_DIV_RESET     7'h02
`define RSD_SKEW_RESET    4'h0
`define RSD_LOCK_MATCHES  4'hf
`define RSD_HTRANS_NONSEQ 2'h2

`endif

// File: rtl/rsd_pkg.sv
package rsd_pkg;

  // ----------------------------------------------------------------
  // Control, configuration and status carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic route;
    logic fb_bypass;
    logic in_bypass;
  } rsd_ctrl_t;

  typedef struct packed {
    logic [3:0] skew;
    logic [6:0] ratio;
  } rsd_out_cfg_t;

  typedef struct packed {
    logic route;
    logic fb_sel;
    logic ref_sel;
    logic lock;
  } rsd_status_t;

endpackage

// File: rtl/rsd_out_divider.sv
`timescale 1ns/1ps
`include "rsd_consts.svh"

module rsd_out_divider (
  input  wire logic                 clock_in,
  input  wire logic                 resetn_in,
  input  wire logic                 tick_in,
  input  wire logic                 half_in,
  input  wire logic                 restart_in,
  input  wire rsd_pkg::rsd_out_cfg_t cfg_in,
  output logic                      clk_out,
  output logic                      edge_out
);
  import rsd_pkg::*;

  logic [6:0] period;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic       clk_q;
  logic       clk_d;
  logic       edge_q;
  logic       edge_d;

  // ----------------------------------------------------------------
  // Counter and output level
  // ----------------------------------------------------------------
  always_comb
  begin
    period = half_in ? {1'b0, cfg_in.ratio[6:1]} : cfg_in.ratio;  // R5
    cnt_d  = cnt_q;
    edge_d = 1'b0;
    if (restart_in)
    begin
      // Skew offset only in loop mode
      if (half_in || ({3'h0, cfg_in.skew} >= period))  // R7
        cnt_d = 7'h00;
      else
        cnt_d = {3'h0, cfg_in.skew};
    end
    else if (tick_in)
    begin
      if (cnt_q >= 7'(period - 7'h01))  // R6
      begin
        cnt_d  = 7'h00;
        edge_d = 1'b1;
      end
      else
        cnt_d = 7'(cnt_q + 7'h01);
    end
    clk_d = (cnt_d < 7'((period + 7'h01) >> 1));
  end

  // Register state
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_q  <= 7'h00;
      clk_q  <= 1'b0;
      edge_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      clk_q  <= clk_d;
      edge_q <= edge_d;
    end
  end

  assign clk_out  = clk_q;
  assign edge_out = edge_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_half_wrap: assert property (@(posedge clock_in) disable iff (!resetn_in) // R5
    half_in && tick_in && !restart_in && cnt_q == 7'({1'b0, cfg_in.ratio[6:1]} - 7'h01)
    |=> edge_out && cnt_q == 7'h00)
    else $error("halved divider did not wrap at half ratio");

  a_route_rate: assert property (@(posedge clock_in) disable iff (!resetn_in) // R6
    half_in && tick_in && !restart_in && cnt_q != 7'({1'b0, cfg_in.ratio[6:1]} - 7'h01)
    |=> !edge_out)
    else $error("halved divider produced an early edge");

  a_skew_off: assert property (@(posedge clock_in) disable iff (!resetn_in) // R7
    restart_in && half_in |=> cnt_q == 7'h00)
    else $error("skew offset applied in route-around mode");

  a_ratio_legal: assert property (@(posedge clock_in) disable iff (!resetn_in) // R12
    !cfg_in.ratio[0] && cfg_in.ratio >= `RSD_DIV_MIN && cfg_in.ratio <= `RSD_DIV_MAX)
    else $error("divider ratio outside even 2 to 80");

endmodule

// File: rtl/rsd_clock_path.sv
// Overview of operation
// R1 - Input and feedback prescalers each bypassable, passing clocks undivided.
// R2 - Glitch-free switching needs both prescalers bypassed and close clock frequencies.
// R3 - Without bypass, user keeps clock high/low times or resets for switchover.
// R4 - Route-around high feeds input prescaler output straight to all output dividers.
// R5 - In route-around each output divider uses half its programmed value.
// R6 - Route-around output frequency is twice reference over prescaler times divider.
// R7 - Route-around disables lock detection and per-output skew.
// R8 - Larger variant: reference select low picks pair A, high picks pair B.
// R9 - Larger variant: feedback select low picks pair A, high picks pair B.
// R10 - Smaller variant has one reference and one feedback pair, no selects.
// R11 - Normal locked mode: outputs are loop oscillator divided by each divider.
// R12 - Output dividers programmable to even ratios 2 to 80.
// R13 - Input prescaler divides reference by integer 1 to 40.
// R14 - Selected feedback pair drives feedback prescaler; selected reference drives input one.
// R15 - Select inputs act directly on input multiplexers, never latched by a clock.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rsd_consts.svh"

module rsd_clock_path #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        reference_pair_a_in,
  input  wire logic        reference_pair_b_in,
  input  wire logic        feedback_pair_a_in,
  input  wire logic        feedback_pair_b_in,
  input  wire logic        reference_pair_select_in,
  input  wire logic        feedback_pair_select_in,
  input  wire logic        vco_in,
  output logic      [4:0]  out_clk_out,
  output logic             ref_phase_pulse_out,
  output logic             fb_phase_pulse_out,
  output logic             lock_out
);
  import rsd_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Clamp a prescaler write into 1 to 40
  function automatic logic [5:0] clamp_pre(input logic [31:0] v);
    if (v[5:0] < `RSD_PRE_MIN || v[31:6] != 26'h0)
      clamp_pre = (v[31:6] != 26'h0) ? `RSD_PRE_MAX : `RSD_PRE_MIN;
    else if (v[5:0] > `RSD_PRE_MAX)
      clamp_pre = `RSD_PRE_MAX;
    else
      clamp_pre = v[5:0];
  endfunction

  // Clamp a divider write into even 2 to 80
  function automatic logic [6:0] clamp_div(input logic [6:0] v);
    if (v < `RSD_DIV_MIN)
      clamp_div = `RSD_DIV_MIN;
    else if (v > `RSD_DIV_MAX)
      clamp_div = `RSD_DIV_MAX;
    else
      clamp_div = {v[6:1], 1'b0};
  endfunction

  // Prescaler stage: tick on the edge that closes a count
  function automatic logic pre_hit(input logic rise, input logic byp,
                                   input logic [5:0] cnt, input logic [5:0] div);
    pre_hit = rise && (byp || cnt == 6'(div - 6'h01));
  endfunction

  // ----------------------------------------------------------------
  // Input multiplexers and synchronisers
  // ----------------------------------------------------------------
  logic       ref_sel_eff;
  logic       fb_sel_eff;
  logic       ref_mux;
  logic       fb_mux;
  logic [2:0] ref_s_q;
  logic [2:0] fb_s_q;
  logic [2:0] vco_s_q;
  logic [1:0] rsel_s_q;
  logic [1:0] fsel_s_q;
  logic       ref_rise;
  logic       fb_rise;
  logic       vco_rise;

  // Select pins steer the pair muxes with no latch
  assign ref_sel_eff = LARGE_VARIANT ? reference_pair_select_in : 1'b0;  // R10
  assign fb_sel_eff  = LARGE_VARIANT ? feedback_pair_select_in : 1'b0;   // R10
  assign ref_mux = ref_sel_eff ? reference_pair_b_in : reference_pair_a_in;  // R8 R15
  assign fb_mux  = fb_sel_eff ? feedback_pair_b_in : feedback_pair_a_in;     // R9 R15

  // Two-stage sync plus edge stage; stage 0 only feeds stage 1
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ref_s_q  <= 3'h0;
      fb_s_q   <= 3'h0;
      vco_s_q  <= 3'h0;
      rsel_s_q <= 2'h0;
      fsel_s_q <= 2'h0;
    end
    else
    begin
      ref_s_q  <= {ref_s_q[1:0], ref_mux};
      fb_s_q   <= {fb_s_q[1:0], fb_mux};
      vco_s_q  <= {vco_s_q[1:0], vco_in};
      rsel_s_q <= {rsel_s_q[0], ref_sel_eff};
      fsel_s_q <= {fsel_s_q[0], fb_sel_eff};
    end
  end

  assign ref_rise = ref_s_q[1] && !ref_s_q[2];
  assign fb_rise  = fb_s_q[1] && !fb_s_q[2];
  assign vco_rise = vco_s_q[1] && !vco_s_q[2];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  rsd_ctrl_t    ctrl_q;
  rsd_ctrl_t    ctrl_d;
  logic [5:0]   in_pre_q;
  logic [5:0]   in_pre_d;
  logic [5:0]   fb_pre_q;
  logic [5:0]   fb_pre_d;
  rsd_out_cfg_t cfg_q [`RSD_NUM_OUT];
  rsd_out_cfg_t cfg_d [`RSD_NUM_OUT];
  logic [4:0]   restart_q;
  logic [4:0]   restart_d;
  logic         wr_pend_q;
  logic         wr_pend_d;
  logic [7:0]   addr_q;
  logic [7:0]   addr_d;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;
  logic         lock_q;
  logic         addr_ok;
  rsd_status_t  status;

  assign addr_ok = hsel_in && htrans_in == `RSD_HTRANS_NONSEQ && hready_in;
  assign status  = '{route: ctrl_q.route, fb_sel: fsel_s_q[1], ref_sel: rsel_s_q[1], lock: lock_q};

  // Address phase capture, data phase write, registered read data
  always_comb
  begin
    ctrl_d    = ctrl_q;
    in_pre_d  = in_pre_q;
    fb_pre_d  = fb_pre_q;
    cfg_d     = cfg_q;
    restart_d = 5'h00;
    wr_pend_d = addr_ok && hwrite_in;
    addr_d    = addr_ok ? haddr_in[7:0] : addr_q;
    rdata_d   = 32'h0000_0000;
    if (wr_pend_q)
    begin
      unique case (addr_q)
        `RSD_OFF_CTRL:
        begin
          ctrl_d.in_bypass = hwdata_in[`RSD_CTRL_IN_BYP];  // R1
          ctrl_d.fb_bypass = hwdata_in[`RSD_CTRL_FB_BYP];  // R1
          ctrl_d.route     = hwdata_in[`RSD_CTRL_ROUTE];   // R4
          if (hwdata_in[`RSD_CTRL_ROUTE] != ctrl_q.route)
            restart_d = 5'h1f;
        end
        `RSD_OFF_IN_PRE: in_pre_d = clamp_pre(hwdata_in);  // R13
        `RSD_OFF_FB_PRE: fb_pre_d = clamp_pre(hwdata_in);
        default:
        begin
          for (int k = 0; k < `RSD_NUM_OUT; k++)
          begin
            if (addr_q == 8'(`RSD_OFF_OUT_BASE + 8'(k) * `RSD_OFF_STRIDE))
            begin
              cfg_d[k].ratio = clamp_div(hwdata_in[`RSD_OUT_RATIO_MSB:`RSD_OUT_RATIO_LSB]);  // R12
              cfg_d[k].skew  = hwdata_in[`RSD_OUT_SKEW_MSB:`RSD_OUT_SKEW_LSB];
              restart_d[k]   = 1'b1;
            end
          end
        end
      endcase
    end
    if (addr_ok && !hwrite_in)
    begin
      unique case (haddr_in[7:0])
        `RSD_OFF_CTRL:   rdata_d = {29'h0000_0000, ctrl_q};
        `RSD_OFF_IN_PRE: rdata_d = {26'h000_0000, in_pre_q};
        `RSD_OFF_FB_PRE: rdata_d = {26'h000_0000, fb_pre_q};
        `RSD_OFF_STATUS: rdata_d = {28'h000_0000, status};
        default:
        begin
          for (int k = 0; k < `RSD_NUM_OUT; k++)
            if (haddr_in[7:0] == 8'(`RSD_OFF_OUT_BASE + 8'(k) * `RSD_OFF_STRIDE))
              rdata_d = {20'h0_0000, cfg_q[k].skew, 1'b0, cfg_q[k].ratio};
        end
      endcase
    end
  end

  // Register the bus slave state
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_q    <= '0;
      in_pre_q  <= `RSD_PRE_RESET;
      fb_pre_q  <= `RSD_PRE_RESET;
      for (int k = 0; k < `RSD_NUM_OUT; k++)
        cfg_q[k] <= '{skew: `RSD_SKEW_RESET, ratio: `RSD_DIV_RESET};
      restart_q <= 5'h00;
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      in_pre_q  <= in_pre_d;
      fb_pre_q  <= fb_pre_d;
      cfg_q     <= cfg_d;
      restart_q <= restart_d;
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
      rdata_q   <= rdata_d;
    end
  end

  // Zero wait state, always OKAY
  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // ----------------------------------------------------------------
  // Prescalers, phase pulses and lock detect
  // ----------------------------------------------------------------
  logic [5:0] m_cnt_q;
  logic [5:0] m_cnt_d;
  logic [5:0] n_cnt_q;
  logic [5:0] n_cnt_d;
  logic       ref_tick;
  logic       fb_tick;
  logic       ref_pend_q;
  logic       ref_pend_d;
  logic       fb_pend_q;
  logic       fb_pend_d;
  logic [3:0] match_q;
  logic [3:0] match_d;
  logic       lock_d;
  logic       rp_q;
  logic       fp_q;

  assign ref_tick = pre_hit(ref_rise, ctrl_q.in_bypass, m_cnt_q, in_pre_q);  // R1 R13 R14
  assign fb_tick  = pre_hit(fb_rise, ctrl_q.fb_bypass, n_cnt_q, fb_pre_q);   // R1 R14

  // Count edges, pair ref and feedback ticks for lock
  always_comb
  begin
    m_cnt_d    = m_cnt_q;
    n_cnt_d    = n_cnt_q;
    ref_pend_d = ref_pend_q;
    fb_pend_d  = fb_pend_q;
    match_d    = match_q;
    if (ref_rise)
      m_cnt_d = (ref_tick || ctrl_q.in_bypass) ? 6'h00 : 6'(m_cnt_q + 6'h01);  // R13
    if (fb_rise)
      n_cnt_d = (fb_tick || ctrl_q.fb_bypass) ? 6'h00 : 6'(n_cnt_q + 6'h01);
    if (ctrl_q.route)
    begin
      ref_pend_d = 1'b0;  // R7
      fb_pend_d  = 1'b0;
      match_d    = 4'h0;
    end
    else if ((ref_tick && ref_pend_q) || (fb_tick && fb_pend_q))
    begin
      ref_pend_d = 1'b0;
      fb_pend_d  = 1'b0;
      match_d    = 4'h0;
    end
    else if ((ref_tick || ref_pend_q) && (fb_tick || fb_pend_q))
    begin
      ref_pend_d = 1'b0;
      fb_pend_d  = 1'b0;
      if (match_q != `RSD_LOCK_MATCHES)
        match_d = 4'(match_q + 4'h1);
    end
    else
    begin
      ref_pend_d = ref_pend_q || ref_tick;
      fb_pend_d  = fb_pend_q || fb_tick;
    end
    lock_d = !ctrl_q.route && match_d == `RSD_LOCK_MATCHES;  // R7
  end

  // Register prescaler and lock state
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_cnt_q    <= 6'h00;
      n_cnt_q    <= 6'h00;
      ref_pend_q <= 1'b0;
      fb_pend_q  <= 1'b0;
      match_q    <= 4'h0;
      lock_q     <= 1'b0;
      rp_q       <= 1'b0;
      fp_q       <= 1'b0;
    end
    else
    begin
      m_cnt_q    <= m_cnt_d;
      n_cnt_q    <= n_cnt_d;
      ref_pend_q <= ref_pend_d;
      fb_pend_q  <= fb_pend_d;
      match_q    <= match_d;
      lock_q     <= lock_d;
      rp_q       <= ref_tick;
      fp_q       <= fb_tick;
    end
  end

  assign ref_phase_pulse_out = rp_q;
  assign fb_phase_pulse_out  = fp_q;
  assign lock_out            = lock_q;

  // ----------------------------------------------------------------
  // Output dividers
  // ----------------------------------------------------------------
  logic div_tick;

  // Route-around feeds the prescaled reference, else the loop oscillator
  assign div_tick = ctrl_q.route ? ref_tick : vco_rise;  // R4 R11

  for (genvar g = 0; g < `RSD_NUM_OUT; g++)
  begin : g_div
    rsd_out_divider u_div (
      .clock_in   (clock_in),
      .resetn_in  (resetn_in),
      .tick_in    (div_tick),
      .half_in    (ctrl_q.route),
      .restart_in (restart_q[g]),
      .cfg_in     (cfg_q[g]),
      .clk_out    (out_clk_out[g]),
      .edge_out   ()
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_in_bypass: assert property (ctrl_q.in_bypass && ref_rise |=> rp_q) // R1
    else $error("bypassed input prescaler dropped an edge");
  a_fb_bypass: assert property (ctrl_q.fb_bypass && fb_rise |=> fp_q) // R1
    else $error("bypassed feedback prescaler dropped an edge");
  a_in_div_count: assert property (ref_tick && !ctrl_q.in_bypass |-> m_cnt_q == 6'(in_pre_q - 6'h01)) // R13
    else $error("input prescaler ticked at wrong count");
  a_route_feed: assert property (ctrl_q.route && $past(ctrl_q.route) |-> div_tick == ref_tick) // R4
    else $error("route-around did not feed prescaled reference");
  a_lock_off: assert property (ctrl_q.route |=> !lock_out) // R7
    else $error("lock reported in route-around mode");
  a_ref_select: assert property (LARGE_VARIANT && $stable(reference_pair_select_in)
    |=> ref_s_q[0] == $past(reference_pair_select_in ? reference_pair_b_in : reference_pair_a_in)) // R8
    else $error("reference pair select chose wrong pair");
  a_fb_select: assert property (LARGE_VARIANT && $stable(feedback_pair_select_in)
    |=> fb_s_q[0] == $past(feedback_pair_select_in ? feedback_pair_b_in : feedback_pair_a_in)) // R9
    else $error("feedback pair select chose wrong pair");
  a_small_pairs: assert property (!LARGE_VARIANT |-> !status.ref_sel && !status.fb_sel) // R10
    else $error("small variant selected pair B");
  a_loop_feed: assert property (!ctrl_q.route |-> div_tick == vco_rise) // R11
    else $error("dividers not fed from loop oscillator");
  a_fb_path: assert property (fb_tick |=> fb_phase_pulse_out ##1 !fb_phase_pulse_out || fb_tick) // R14
    else $error("feedback tick not passed to phase pulse");

  c_route_tick: cover property (ctrl_q.route && ref_tick);
  c_locked: cover property ($rose(lock_out));
  c_ref_switch: cover property ($rose(status.ref_sel));
  c_prescale: cover property (ref_tick && !ctrl_q.in_bypass && in_pre_q > 6'h01);

endmodule

// File: test/rsd_board_model.sv
`timescale 1ns/1ps

module rsd_board_model #(
  parameter int RA_HALF  = 4,
  parameter int RB_HALF  = 6,
  parameter int FA_HALF  = 4,
  parameter int FB_HALF  = 8,
  parameter int VCO_HALF = 2
) (
  input  wire logic clock_in,
  input  wire logic run_in,
  output logic      reference_pair_a_out,
  output logic      reference_pair_b_out,
  output logic      feedback_pair_a_out,
  output logic      feedback_pair_b_out,
  output logic      vco_out
);
  int cnt_q;
  int cnt_d;

  // Square wave, still while stopped
  function automatic logic wave(input int c, input int h);
    return run_in && ((c / h) % 2 == 1);
  endfunction

  // Time base runs with the sources
  always_comb
  begin
    cnt_d = run_in ? cnt_q + 1 : 0;
  end

  always_ff @(posedge clock_in)
  begin
    cnt_q <= cnt_d;
  end

  // Feedback offset keeps ticks alternating
  assign reference_pair_a_out = wave(cnt_q, RA_HALF);
  assign reference_pair_b_out = wave(cnt_q, RB_HALF);
  assign feedback_pair_a_out  = wave(cnt_q + 2, FA_HALF);
  assign feedback_pair_b_out  = wave(cnt_q + 2, FB_HALF);
  assign vco_out              = wave(cnt_q, VCO_HALF);
endmodule

// File: test/ref_select_divider_bypass_test.sv
`timescale 1ns/1ps
`include "rsd_consts.svh"

module ref_select_divider_bypass_test;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int RA = 4, RB = 6, FA = 4, FB = 8, VH = 2;
  logic        clock_in, resetn_in, hsel, hwrite, hready, hresp, run;
  logic        ref_a, ref_b, fb_a, fb_b, vco, ref_sel, fb_sel, ref_p, fb_p, lock, small_ref_p;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  out_clk;
  int          fails, n_tests;

  rsd_clock_path #(.LARGE_VARIANT(1'b1)) rsd_clock_path_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .reference_pair_a_in(ref_a), .reference_pair_b_in(ref_b), .feedback_pair_a_in(fb_a),
    .feedback_pair_b_in(fb_b), .reference_pair_select_in(ref_sel),
    .feedback_pair_select_in(fb_sel), .vco_in(vco), .out_clk_out(out_clk),
    .ref_phase_pulse_out(ref_p), .fb_phase_pulse_out(fb_p), .lock_out(lock));

  // Single-pair variant ignores the selects
  rsd_clock_path #(.LARGE_VARIANT(1'b0)) rsd_clock_path_small_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .hsel_in(1'b0), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(), .hreadyout_out(), .hresp_out(),
    .reference_pair_a_in(ref_a), .reference_pair_b_in(ref_b), .feedback_pair_a_in(fb_a),
    .feedback_pair_b_in(fb_b), .reference_pair_select_in(ref_sel),
    .feedback_pair_select_in(fb_sel), .vco_in(vco), .out_clk_out(),
    .ref_phase_pulse_out(small_ref_p), .fb_phase_pulse_out(), .lock_out());

  rsd_board_model #(.RA_HALF(RA), .RB_HALF(RB), .FA_HALF(FA), .FB_HALF(FB), .VCO_HALF(VH))
  rsd_board_model_inst (
    .clock_in(clock_in), .run_in(run), .reference_pair_a_out(ref_a),
    .reference_pair_b_out(ref_b), .feedback_pair_a_out(fb_a),
    .feedback_pair_b_out(fb_b), .vco_out(vco));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic give_up(input string what);
    fails++;
    $display("unexpected at %0t: no answer in %s", $time, what);
    wrap_up();
  endtask

  // Address phase then data phase, each held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clock_in);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= `RSD_HTRANS_NONSEQ;
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++)
    begin
      n = 0;
      do
      begin
        @(posedge clock_in);
        if (++n > 50)
          give_up("bus");
      end
      while (hready !== 1'b1);
      if (ph == 0)
      begin
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, exp, what);
  endtask

  function automatic logic sig(input int code);
    case (code)
      5: return ref_p;
      6: return fb_p;
      7: return small_ref_p;
      default: return out_clk[code];
    endcase
  endfunction

  // Cycles between second and third rise
  task automatic per(input int code, input int exp, input string what);
    logic prev = 1'b1;
    logic cur;
    int   n    = 0;
    int   t0   = 0;
    int   hits = 0;
    repeat (40) @(posedge clock_in);
    while (hits < 3)
    begin
      @(negedge clock_in);
      cur = sig(code);
      if (cur === 1'b1 && prev === 1'b0)
      begin
        if (hits == 2)
          check(n - t0, exp, what);
        t0 = n;
        hits++;
      end
      prev = cur;
      n++;
      if (n > 3000)
        give_up(what);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(`RSD_OFF_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(`RSD_OFF_IN_PRE, 32'h0000_0001, "in prescaler reset");
    rd_chk(`RSD_OFF_FB_PRE, 32'h0000_0001, "fb prescaler reset");
    for (int k = 0; k < `RSD_NUM_OUT; k++)
      rd_chk(`RSD_OFF_OUT_BASE + `RSD_OFF_STRIDE * 8'(k), 32'h0000_0002, "divider reset");
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    check(hresp, 32'h0000_0000, "response");
    $display("test reset done");
  endtask

  task automatic t_clamp;
    logic [31:0] pv [4];
    logic [31:0] pe [4];
    logic [31:0] dv [4];
    logic [31:0] de [4];
    pv = '{32'h0000_0000, 32'h0000_0029, 32'h0000_0028, 32'h0000_0007};
    pe = '{32'h0000_0001, 32'h0000_0028, 32'h0000_0028, 32'h0000_0007};
    dv = '{32'h0000_0051, 32'h0000_0003, 32'h0000_0007, 32'h0000_0001};
    de = '{32'h0000_0050, 32'h0000_0002, 32'h0000_0006, 32'h0000_0002};
    for (int i = 0; i < 4; i++)
    begin
      wr(`RSD_OFF_IN_PRE, pv[i]);
      rd_chk(`RSD_OFF_IN_PRE, pe[i], "prescaler range");
      wr(`RSD_OFF_OUT_BASE, dv[i]);
      rd_chk(`RSD_OFF_OUT_BASE, de[i], "divider range");
    end
    $display("test clamp done");
  endtask

  task automatic t_route;
    wr(`RSD_OFF_IN_PRE, 32'h0000_0001);
    wr(`RSD_OFF_OUT_BASE, 32'h0000_0004);
    wr(`RSD_OFF_OUT_BASE + `RSD_OFF_STRIDE, 32'h0000_0050);
    wr(`RSD_OFF_CTRL, 32'h0000_0005);
    per(5, 2 * RA, "bypassed ref tick");
    per(0, 2 * 2 * RA, "route divider 4");
    per(1, 40 * 2 * RA, "route divider 80");
    check(lock, 32'h0000_0000, "lock in route");
    wr(`RSD_OFF_IN_PRE, 32'h0000_0003);
    wr(`RSD_OFF_CTRL, 32'h0000_0004);
    per(5, 3 * 2 * RA, "prescaled ref tick");
    per(0, 2 * 3 * 2 * RA, "route with prescaler");
    check(lock, 32'h0000_0000, "lock in route");
    $display("test route done");
  endtask

  task automatic t_select;
    logic [31:0] x;
    wr(`RSD_OFF_CTRL, 32'h0000_0003);
    per(5, 2 * RA, "ref pair a");
    per(6, 2 * FA, "fb pair a");
    @(posedge clock_in);
    ref_sel <= 1'b1;
    fb_sel  <= 1'b1;
    per(5, 2 * RB, "ref pair b");
    per(6, 2 * FB, "fb pair b");
    per(7, 2 * RA, "single pair variant");
    bus(1'b0, `RSD_OFF_STATUS, 32'h0000_0000, x);
    check(x[2:1], 32'h0000_0003, "select status");
    @(posedge clock_in);
    ref_sel <= 1'b0;
    fb_sel  <= 1'b0;
    per(5, 2 * RA, "ref pair a again");
    $display("test select done");
  endtask

  task automatic t_loop;
    int n;
    wr(`RSD_OFF_FB_PRE, 32'h0000_0002);
    wr(`RSD_OFF_CTRL, 32'h0000_0001);
    per(6, 2 * 2 * FA, "fb prescaler on");
    wr(`RSD_OFF_FB_PRE, 32'h0000_0001);
    wr(`RSD_OFF_IN_PRE, 32'h0000_0001);
    wr(`RSD_OFF_CTRL, 32'h0000_0000);
    wr(`RSD_OFF_OUT_BASE + `RSD_OFF_STRIDE * 8'd2, 32'h0000_0006);
    per(2, 6 * 2 * VH, "loop divider 6");
    n = 0;
    while (lock !== 1'b1 && n < 1000)
    begin
      @(posedge clock_in);
      n++;
    end
    check(lock, 32'h0000_0001, "lock on paired ticks");
    wr(`RSD_OFF_CTRL, 32'h0000_0004);
    repeat (8) @(posedge clock_in);
    check(lock, 32'h0000_0000, "lock dropped by route");
    $display("test loop done");
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Main sequence
  initial
  begin
    fails     = 0;
    n_tests   = 0;
    resetn_in = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0000_0000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0000_0000;
    run       = 1'b0;
    ref_sel   = 1'b0;
    fb_sel    = 1'b0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    run       <= 1'b1;
    t_reset();
    t_clamp();
    t_route();
    t_select();
    t_loop();
    wrap_up();
  end
endmodule
